// >>> pefg_map.vh
// Purpose: shared constants for the port E/F/G override multiplexer
// Assumes: included by pefg_override_mux.v and pefg_pin_slice.v
// Notes: pin index positions within each port and register reset values
// Functional notes
// - serial 0 receiver enabled forces port E bit 0 to input
// - forced E0 input keeps pull-up when data bit one and pull-ups allowed
// - timer3 compare C/B drive E5/E4; interrupt enables force E7..E4 input on
// - serial 0 transmitter: E1 pull-up off, output, value from transmit data
// - E2 driven by external clock in sync mode; E3 by timer3 compare B
// - legacy compatibility mode makes every port F pin input only, except F6 while the test port shifts
// - test port pull-ups on data in, mode select, clock stay on, even in reset
// - test port enabled: F7..F4 overridden, pull-up on (off on F6), input, digital input off
// - test data out drives only in shift states, floats otherwise
// - F3..F0 carry no override outside legacy mode; analog inputs only
// - legacy mode: port G only alternate functions; idle pins parked as inputs, digital input on
// - timer 0 async: G4, G3 pull-up off, input, digital input off
// - memory interface: G2, G1 pull-up off, output, latch and read strobes
// - memory interface: G0 pull-up off, output, write strobe
`ifndef PEFG_MAP_VH
`define PEFG_MAP_VH

`define PEFG_E_WIDTH 8
`define PEFG_F_WIDTH 8
`define PEFG_G_WIDTH 5

`define PEFG_E_RX_BIT 0
`define PEFG_E_TX_BIT 1
`define PEFG_E_XCK_BIT 2
`define PEFG_E_OCA_BIT 3
`define PEFG_E_OCB_BIT 4
`define PEFG_E_OCC_BIT 5
`define PEFG_E_IRQ6_BIT 6
`define PEFG_E_IRQ7_BIT 7

`define PEFG_F_TCK_BIT 4
`define PEFG_F_TMS_BIT 5
`define PEFG_F_TDO_BIT 6
`define PEFG_F_TDI_BIT 7

`define PEFG_G_WR_BIT 0
`define PEFG_G_RD_BIT 1
`define PEFG_G_ALE_BIT 2
`define PEFG_G_OSCB_BIT 3
`define PEFG_G_OSCA_BIT 4

`define PEFG_E_PULLUP_RST 8'h00
`define PEFG_F_PULLUP_RST 8'hB0
`define PEFG_G_PULLUP_RST 5'h00

`endif

// >>> pefg_pin_slice.v
// Purpose: one port's override merge with registered pin controls
// Assumes: override vectors and register bits come from core_clk logic
// Notes: pin levels are synchronised before the input enable gates them
`timescale 1ns/1ps
`include "pefg_map.vh"

module pefg_pin_slice #(
  parameter W = 8,
  parameter [W-1:0] PULLUP_RST = {W{1'b0}}
) (
  input wire core_clk,
  input wire rst,
  input wire [W-1:0] port_data,
  input wire [W-1:0] port_direction,
  input wire global_pullup_disable,
  input wire [W-1:0] pullup_override_en,
  input wire [W-1:0] pullup_override_val,
  input wire [W-1:0] direction_override_en,
  input wire [W-1:0] direction_override_val,
  input wire [W-1:0] value_override_en,
  input wire [W-1:0] value_override_val,
  input wire [W-1:0] input_enable_override_en,
  input wire [W-1:0] input_enable_override_val,
  input wire [W-1:0] pin_in,
  output reg [W-1:0] pullup_on_reg,
  output reg [W-1:0] drive_oe_n_reg,
  output reg [W-1:0] drive_val_reg,
  output reg [W-1:0] din_reg
);

  reg [W-1:0] sync1_reg;
  reg [W-1:0] sync2_reg;
  reg [W-1:0] pullup_next;
  reg [W-1:0] dir_next;
  reg [W-1:0] val_next;
  reg [W-1:0] die_next;

  // plain pull-up: data bit one on an input, unless pull-ups are disabled globally
  always @* begin
    pullup_next = (pullup_override_en & pullup_override_val) |
                  (~pullup_override_en & port_data & ~port_direction &
                   {W{~global_pullup_disable}});
    dir_next = (direction_override_en & direction_override_val) |
               (~direction_override_en & port_direction);
    val_next = (value_override_en & value_override_val) |
               (~value_override_en & port_data);
    die_next = (input_enable_override_en & input_enable_override_val) |
               ~input_enable_override_en;
  end

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sync1_reg <= {W{1'b0}};
      sync2_reg <= {W{1'b0}};
      pullup_on_reg <= PULLUP_RST;
      drive_oe_n_reg <= {W{1'b1}};
      drive_val_reg <= {W{1'b0}};
      din_reg <= {W{1'b0}};
    end else begin
      sync1_reg <= pin_in;
      sync2_reg <= sync1_reg;
      pullup_on_reg <= pullup_next;
      drive_oe_n_reg <= ~dir_next;
      drive_val_reg <= val_next;
      din_reg <= sync2_reg & die_next;
    end
  end

endmodule

// >>> pefg_override_mux.v
// Purpose: alternate-function override merge for ports E, F and G
// Assumes: peripheral controls arrive on core_clk; pin levels are asynchronous
// Notes: every pin control is registered, so overrides act one edge late
`timescale 1ns/1ps
`include "pefg_map.vh"

module pefg_override_mux (
  input wire core_clk,
  input wire rst,
  input wire global_pullup_disable,
  input wire legacy_compat_mode,
  input wire [7:0] port_e_data,
  input wire [7:0] port_e_direction,
  input wire [7:0] port_f_data,
  input wire [7:0] port_f_direction,
  input wire [4:0] port_g_data,
  input wire [4:0] port_g_direction,
  input wire serial0_rx_enable,
  input wire serial0_tx_enable,
  input wire serial0_tx_out,
  input wire serial0_sync_select,
  input wire serial0_ext_clock,
  input wire timer3_compare_b_en,
  input wire timer3_compare_b_out,
  input wire timer3_compare_c_en,
  input wire timer3_compare_c_out,
  input wire ext_irq_line_4_en,
  input wire ext_irq_line_5_en,
  input wire ext_irq_line_6_en,
  input wire ext_irq_line_7_en,
  input wire test_port_enable,
  input wire tap_shift_instr_state,
  input wire tap_shift_data_state,
  input wire test_data_out,
  input wire timer0_async_select,
  input wire ext_memory_enable,
  input wire ext_mem_latch_strobe,
  input wire ext_mem_read_strobe,
  input wire ext_mem_write_strobe,
  input wire [7:0] pin_e_in,
  input wire [7:0] pin_f_in,
  input wire [4:0] pin_g_in,
  output wire [7:0] pin_e_pullup,
  output wire [7:0] pin_e_oe_n,
  output wire [7:0] pin_e_out,
  output wire [7:0] port_e_din,
  output wire [7:0] pin_f_pullup,
  output wire [7:0] pin_f_oe_n,
  output wire [7:0] pin_f_out,
  output wire [7:0] port_f_din,
  output wire [4:0] pin_g_pullup,
  output wire [4:0] pin_g_oe_n,
  output wire [4:0] pin_g_out,
  output wire [4:0] port_g_din
);

  reg [7:0] e_pullup_override_en;
  reg [7:0] e_pullup_override_val;
  reg [7:0] e_direction_override_en;
  reg [7:0] e_direction_override_val;
  reg [7:0] e_value_override_en;
  reg [7:0] e_value_override_val;
  reg [7:0] e_input_enable_override_en;
  reg [7:0] e_input_enable_override_val;

  reg [7:0] f_pullup_override_en;
  reg [7:0] f_pullup_override_val;
  reg [7:0] f_direction_override_en;
  reg [7:0] f_direction_override_val;
  reg [7:0] f_value_override_en;
  reg [7:0] f_value_override_val;
  reg [7:0] f_input_enable_override_en;
  reg [7:0] f_input_enable_override_val;

  reg [4:0] g_pullup_override_en;
  reg [4:0] g_pullup_override_val;
  reg [4:0] g_direction_override_en;
  reg [4:0] g_direction_override_val;
  reg [4:0] g_value_override_en;
  reg [4:0] g_value_override_val;
  reg [4:0] g_input_enable_override_en;
  reg [4:0] g_input_enable_override_val;
  reg [4:0] g_alt_active;

  wire tap_shifting;

  // either shift state lets the test data out pin drive
  assign tap_shifting = tap_shift_instr_state | tap_shift_data_state;

  // legacy parking clears the direction and value bits of a pin whose alternate function is idle
  function [4:0] pefg_park;
    input [4:0] vec;
    input [4:0] keep;
    begin
      pefg_park = vec & keep;
    end
  endfunction

  // port E overrides
  always @* begin
    e_pullup_override_en = 8'h00;
    e_pullup_override_val = 8'h00;
    e_direction_override_en = 8'h00;
    e_direction_override_val = 8'h00;
    e_value_override_en = 8'h00;
    e_value_override_val = 8'h00;
    e_input_enable_override_en = 8'h00;
    e_input_enable_override_val = 8'h00;
    // receive pin: input regardless of direction bit
    e_pullup_override_en[`PEFG_E_RX_BIT] = serial0_rx_enable;
    e_pullup_override_val[`PEFG_E_RX_BIT] = port_e_data[`PEFG_E_RX_BIT] & ~global_pullup_disable;
    e_direction_override_en[`PEFG_E_RX_BIT] = serial0_rx_enable;
    e_direction_override_val[`PEFG_E_RX_BIT] = 1'b0;

    // transmit pin
    e_pullup_override_en[`PEFG_E_TX_BIT] = serial0_tx_enable;
    e_pullup_override_val[`PEFG_E_TX_BIT] = 1'b0;
    e_direction_override_en[`PEFG_E_TX_BIT] = serial0_tx_enable;
    e_direction_override_val[`PEFG_E_TX_BIT] = 1'b1;
    e_value_override_en[`PEFG_E_TX_BIT] = serial0_tx_enable;
    e_value_override_val[`PEFG_E_TX_BIT] = serial0_tx_out;

    // clock pin direction stays with the direction bit, so the clock may be an input
    e_value_override_en[`PEFG_E_XCK_BIT] = serial0_sync_select;
    e_value_override_val[`PEFG_E_XCK_BIT] = serial0_ext_clock;
    // pin E3 follows compare B; no compare A input reaches this block
    e_value_override_en[`PEFG_E_OCA_BIT] = timer3_compare_b_en;
    e_value_override_val[`PEFG_E_OCA_BIT] = timer3_compare_b_out;

    // compare outputs still need the direction bit set by software
    e_value_override_en[`PEFG_E_OCB_BIT] = timer3_compare_b_en;
    e_value_override_val[`PEFG_E_OCB_BIT] = timer3_compare_b_out;
    e_value_override_en[`PEFG_E_OCC_BIT] = timer3_compare_c_en;
    e_value_override_val[`PEFG_E_OCC_BIT] = timer3_compare_c_out;

    // interrupt lines must sample even when input enable would be off
    e_input_enable_override_en[`PEFG_E_OCB_BIT] = ext_irq_line_4_en;
    e_input_enable_override_val[`PEFG_E_OCB_BIT] = 1'b1;
    e_input_enable_override_en[`PEFG_E_OCC_BIT] = ext_irq_line_5_en;
    e_input_enable_override_val[`PEFG_E_OCC_BIT] = 1'b1;
    e_input_enable_override_en[`PEFG_E_IRQ6_BIT] = ext_irq_line_6_en;
    e_input_enable_override_val[`PEFG_E_IRQ6_BIT] = 1'b1;
    e_input_enable_override_en[`PEFG_E_IRQ7_BIT] = ext_irq_line_7_en;
    e_input_enable_override_val[`PEFG_E_IRQ7_BIT] = 1'b1;
  end

  // port F overrides; bits 3..0 carry none outside legacy mode
  always @* begin
    f_pullup_override_en = 8'h00;
    f_pullup_override_val = 8'h00;
    f_direction_override_en = 8'h00;
    f_direction_override_val = 8'h00;
    f_value_override_en = 8'h00;
    f_value_override_val = 8'h00;
    f_input_enable_override_en = 8'h00;
    f_input_enable_override_val = 8'h00;

    // legacy input-only goes first so the test port can still claim F7..F4
    if (legacy_compat_mode) begin
      // pull-up and input enable keep their ordinary behaviour
      f_direction_override_en = 8'hFF;
      f_direction_override_val = 8'h00;
    end

    if (test_port_enable) begin
      f_pullup_override_en[7:4] = 4'hF;
      f_pullup_override_val[`PEFG_F_TDI_BIT] = 1'b1;
      f_pullup_override_val[`PEFG_F_TMS_BIT] = 1'b1;
      f_pullup_override_val[`PEFG_F_TCK_BIT] = 1'b1;
      f_pullup_override_val[`PEFG_F_TDO_BIT] = 1'b0;
      f_direction_override_en[7:4] = 4'hF;
      f_direction_override_val[`PEFG_F_TDO_BIT] = tap_shifting;
      f_value_override_en[`PEFG_F_TDO_BIT] = 1'b1;
      f_value_override_val[`PEFG_F_TDO_BIT] = test_data_out;
      f_input_enable_override_en[7:4] = 4'hF;
      f_input_enable_override_val[7:4] = 4'h0;
    end
  end

  // port G overrides
  always @* begin
    g_pullup_override_en = 5'h00;
    g_pullup_override_val = 5'h00;
    g_direction_override_en = 5'h00;
    g_direction_override_val = 5'h00;
    g_value_override_en = 5'h00;
    g_value_override_val = 5'h00;
    g_input_enable_override_en = 5'h00;
    g_input_enable_override_val = 5'h00;
    // oscillator pins: digital input off keeps the crystal free of a logic load
    if (timer0_async_select) begin
      g_pullup_override_en[`PEFG_G_OSCA_BIT] = 1'b1;
      g_pullup_override_en[`PEFG_G_OSCB_BIT] = 1'b1;
      g_direction_override_en[`PEFG_G_OSCA_BIT] = 1'b1;
      g_direction_override_en[`PEFG_G_OSCB_BIT] = 1'b1;
      g_input_enable_override_en[`PEFG_G_OSCA_BIT] = 1'b1;
      g_input_enable_override_en[`PEFG_G_OSCB_BIT] = 1'b1;
    end

    // memory strobes may share the port with the oscillator pins
    if (ext_memory_enable) begin
      g_pullup_override_en[`PEFG_G_ALE_BIT] = 1'b1;
      g_pullup_override_en[`PEFG_G_RD_BIT] = 1'b1;
      g_direction_override_en[`PEFG_G_ALE_BIT] = 1'b1;
      g_direction_override_en[`PEFG_G_RD_BIT] = 1'b1;
      g_direction_override_val[`PEFG_G_ALE_BIT] = 1'b1;
      g_direction_override_val[`PEFG_G_RD_BIT] = 1'b1;
      g_value_override_en[`PEFG_G_ALE_BIT] = 1'b1;
      g_value_override_en[`PEFG_G_RD_BIT] = 1'b1;
      g_value_override_val[`PEFG_G_ALE_BIT] = ext_mem_latch_strobe;
      g_value_override_val[`PEFG_G_RD_BIT] = ext_mem_read_strobe;
      g_pullup_override_en[`PEFG_G_WR_BIT] = 1'b1;
      g_direction_override_en[`PEFG_G_WR_BIT] = 1'b1;
      g_direction_override_val[`PEFG_G_WR_BIT] = 1'b1;
      g_value_override_en[`PEFG_G_WR_BIT] = 1'b1;
      g_value_override_val[`PEFG_G_WR_BIT] = ext_mem_write_strobe;
    end

    // legacy: a pin with no alternate active is parked as an input, digital input on
    g_alt_active = g_direction_override_en;
    if (legacy_compat_mode) begin
      g_pullup_override_en = 5'h1F;
      g_direction_override_en = 5'h1F;
      g_value_override_en = 5'h1F;
      g_input_enable_override_en = g_input_enable_override_en | ~g_alt_active;
      g_input_enable_override_val = g_input_enable_override_val | ~g_alt_active;
      g_direction_override_val = pefg_park(g_direction_override_val, g_alt_active);
      g_value_override_val = pefg_park(g_value_override_val, g_alt_active);
    end
  end

  // one slice per port; pad levels are synchronised inside each slice
  pefg_pin_slice #(
    .W(`PEFG_E_WIDTH),
    .PULLUP_RST(`PEFG_E_PULLUP_RST)
  ) u_port_e (
    .core_clk(core_clk),
    .rst(rst),
    .port_data(port_e_data),
    .port_direction(port_e_direction),
    .global_pullup_disable(global_pullup_disable),
    .pullup_override_en(e_pullup_override_en),
    .pullup_override_val(e_pullup_override_val),
    .direction_override_en(e_direction_override_en),
    .direction_override_val(e_direction_override_val),
    .value_override_en(e_value_override_en),
    .value_override_val(e_value_override_val),
    .input_enable_override_en(e_input_enable_override_en),
    .input_enable_override_val(e_input_enable_override_val),
    .pin_in(pin_e_in),
    .pullup_on_reg(pin_e_pullup),
    .drive_oe_n_reg(pin_e_oe_n),
    .drive_val_reg(pin_e_out),
    .din_reg(port_e_din)
  );

  // port F resets with the test pull-ups on so they hold through reset
  pefg_pin_slice #(
    .W(`PEFG_F_WIDTH),
    .PULLUP_RST(`PEFG_F_PULLUP_RST)
  ) u_port_f (
    .core_clk(core_clk),
    .rst(rst),
    .port_data(port_f_data),
    .port_direction(port_f_direction),
    .global_pullup_disable(global_pullup_disable),
    .pullup_override_en(f_pullup_override_en),
    .pullup_override_val(f_pullup_override_val),
    .direction_override_en(f_direction_override_en),
    .direction_override_val(f_direction_override_val),
    .value_override_en(f_value_override_en),
    .value_override_val(f_value_override_val),
    .input_enable_override_en(f_input_enable_override_en),
    .input_enable_override_val(f_input_enable_override_val),
    .pin_in(pin_f_in),
    .pullup_on_reg(pin_f_pullup),
    .drive_oe_n_reg(pin_f_oe_n),
    .drive_val_reg(pin_f_out),
    .din_reg(port_f_din)
  );

  pefg_pin_slice #(
    .W(`PEFG_G_WIDTH),
    .PULLUP_RST(`PEFG_G_PULLUP_RST)
  ) u_port_g (
    .core_clk(core_clk),
    .rst(rst),
    .port_data(port_g_data),
    .port_direction(port_g_direction),
    .global_pullup_disable(global_pullup_disable),
    .pullup_override_en(g_pullup_override_en),
    .pullup_override_val(g_pullup_override_val),
    .direction_override_en(g_direction_override_en),
    .direction_override_val(g_direction_override_val),
    .value_override_en(g_value_override_en),
    .value_override_val(g_value_override_val),
    .input_enable_override_en(g_input_enable_override_en),
    .input_enable_override_val(g_input_enable_override_val),
    .pin_in(pin_g_in),
    .pullup_on_reg(pin_g_pullup),
    .drive_oe_n_reg(pin_g_oe_n),
    .drive_val_reg(pin_g_out),
    .din_reg(port_g_din)
  );

endmodule

// >>> pefg_periph_model.sv
// Purpose: behavioural peripheral side that feeds the override values
// Assumes: lvl is set by the bench one cycle before the mux samples it
// Notes: outputs are registered, as the peripherals' own flops would be
`timescale 1ns/1ps
module pefg_periph_model (
  input wire core_clk,
  input wire rst,
  input wire [7:0] lvl,
  output reg serial0_tx_out, serial0_ext_clock, timer3_compare_b_out, timer3_compare_c_out,
  output reg test_data_out, ext_mem_latch_strobe, ext_mem_read_strobe, ext_mem_write_strobe
);
  // reset parks every strobe low so nothing moves before the bench asks
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      {serial0_tx_out, serial0_ext_clock, timer3_compare_b_out, timer3_compare_c_out,
       test_data_out, ext_mem_latch_strobe, ext_mem_read_strobe, ext_mem_write_strobe} <= 8'h00;
    end else begin
      {serial0_tx_out, serial0_ext_clock, timer3_compare_b_out, timer3_compare_c_out,
       test_data_out, ext_mem_latch_strobe, ext_mem_read_strobe, ext_mem_write_strobe} <= lvl;
    end
  end
endmodule

// >>> pefg_override_mux_sva.sv
// Purpose: port-level checks of the E/F/G override merge
// Assumes: every output is registered one edge after its controls
// Notes: pad inputs need three edges, so the sync check waits for a quiet pad
`timescale 1ns/1ps
module pefg_override_mux_sva (
  input wire core_clk, rst, global_pullup_disable, legacy_compat_mode,
  input wire [7:0] port_e_data, port_f_data, port_f_direction, pin_e_in,
  input wire serial0_rx_enable, serial0_tx_enable, serial0_tx_out, serial0_sync_select,
  input wire serial0_ext_clock, timer3_compare_b_en, timer3_compare_b_out,
  input wire timer3_compare_c_en, timer3_compare_c_out, test_port_enable, test_data_out,
  input wire tap_shift_instr_state, tap_shift_data_state, timer0_async_select,
  input wire ext_memory_enable, ext_mem_latch_strobe, ext_mem_read_strobe, ext_mem_write_strobe,
  input wire [7:0] pin_e_pullup, pin_e_oe_n, pin_e_out, port_e_din,
  input wire [7:0] pin_f_pullup, pin_f_oe_n, pin_f_out, port_f_din,
  input wire [4:0] pin_g_pullup, pin_g_oe_n, pin_g_out, port_g_din
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  a_rx_input: assert property (serial0_rx_enable |=> pin_e_oe_n[0] &&
    pin_e_pullup[0] == $past(port_e_data[0] & !global_pullup_disable)) else $error("rx pin");
  a_tx_drive: assert property (serial0_tx_enable |=> !pin_e_oe_n[1] && !pin_e_pullup[1] &&
    pin_e_out[1] == $past(serial0_tx_out)) else $error("tx pin");
  a_ocb_value: assert property (timer3_compare_b_en |=>
    pin_e_out[4:3] == {2{$past(timer3_compare_b_out)}}) else $error("compare b value");
  a_occ_value: assert property (timer3_compare_c_en |=>
    pin_e_out[5] == $past(timer3_compare_c_out)) else $error("compare c value");
  a_xck_value: assert property (serial0_sync_select |=>
    pin_e_out[2] == $past(serial0_ext_clock)) else $error("ext clock value");
  a_legacy_f_in: assert property (legacy_compat_mode |=>
    (pin_f_oe_n | 8'h40) == 8'hFF) else $error("legacy port f drives");
  a_test_pins: assert property (test_port_enable |=> pin_f_pullup[7:4] == 4'hB &&
    port_f_din[7:4] == 4'h0 && pin_f_oe_n[7] && pin_f_oe_n[5] && pin_f_oe_n[4])
    else $error("test pins");
  a_tdo_window: assert property (test_port_enable |=> pin_f_out[6] == $past(test_data_out) &&
    pin_f_oe_n[6] == !$past(tap_shift_instr_state || tap_shift_data_state))
    else $error("test data out");
  a_f_low_plain: assert property (!legacy_compat_mode |=>
    pin_f_out[3:0] == $past(port_f_data[3:0]) && pin_f_oe_n[3:0] == ~$past(port_f_direction[3:0]))
    else $error("analog pins overridden");
  a_osc_detach: assert property (timer0_async_select |=> pin_g_oe_n[4:3] == 2'b11 &&
    pin_g_pullup[4:3] == 2'b00 && port_g_din[4:3] == 2'b00) else $error("osc pins");
  a_mem_strobe: assert property (ext_memory_enable |=> pin_g_oe_n[2:0] == 3'h0 &&
    pin_g_pullup[2:0] == 3'h0 && pin_g_out[2:0] ==
    $past({ext_mem_latch_strobe, ext_mem_read_strobe, ext_mem_write_strobe}))
    else $error("memory strobes");
  a_legacy_g: assert property (legacy_compat_mode && !timer0_async_select &&
    !ext_memory_enable |=> pin_g_oe_n == 5'h1F && pin_g_out == 5'h00) else $error("legacy g");
  a_pin_sync: assert property ($stable(pin_e_in)[*4] |-> port_e_din == pin_e_in)
    else $error("pad sync");
endmodule
bind pefg_override_mux pefg_override_mux_sva u_pefg_override_mux_sva (.*);

// >>> pefg_override_mux_tb.sv
// Purpose: self-checking bench for the E/F/G override merge
// Assumes: three edges settle any row (peripheral flop, mux flop, pad sync)
// Notes: pads stay high in the rows, so din shows the input enable alone
`timescale 1ns/1ps
module pefg_override_mux_tb;
  typedef struct packed {
    logic [15:0] ctl;
    logic [7:0] lvl, ed, edir, fd, fdir;
    logic [4:0] gd, gdir;
    logic [7:0] epu, eoen, eout, edin, fpu, foen, fout, fdin;
    logic [4:0] gpu, goen, gout, gdin;
  } pefg_row_t;
  // ctl: pud legacy rx tx, sync ocb occ irq7, irq6 irq5 irq4 test, shir shdr async mem
  // lvl: tx_out xck ocb occ tdo ale rd wr
  pefg_row_t rows [7] = '{
    '{16'h0000, 8'h00, 8'hA5, 8'h0F, 8'h3C, 8'hF0, 5'h15, 5'h0A, 8'hA0, 8'hF0, 8'hA5,
      8'hFF, 8'h0C, 8'h0F, 8'h3C, 8'hFF, 5'h15, 5'h15, 5'h15, 5'h1F},
    '{16'h8000, 8'h00, 8'hA5, 8'h0F, 8'h3C, 8'hF0, 5'h15, 5'h0A, 8'h00, 8'hF0, 8'hA5,
      8'hFF, 8'h00, 8'h0F, 8'h3C, 8'hFF, 5'h00, 5'h15, 5'h15, 5'h1F},
    '{16'h3FE0, 8'h20, 8'h27, 8'h01, 8'h00, 8'h00, 5'h00, 5'h00, 8'h25, 8'hFD, 8'h19,
      8'hFF, 8'h00, 8'hFF, 8'h00, 8'hFF, 5'h00, 5'h1F, 5'h00, 5'h1F},
    '{16'hA000, 8'h40, 8'h01, 8'h01, 8'h00, 8'h00, 5'h00, 5'h00, 8'h00, 8'hFF, 8'h01,
      8'hFF, 8'h00, 8'hFF, 8'h00, 8'hFF, 5'h00, 5'h1F, 5'h00, 5'h1F},
    '{16'h0018, 8'h08, 8'h00, 8'h00, 8'hF3, 8'h05, 5'h00, 5'h00, 8'h00, 8'hFF, 8'h00,
      8'hFF, 8'hB2, 8'hBA, 8'hF3, 8'h0F, 5'h00, 5'h1F, 5'h00, 5'h1F},
    '{16'h4010, 8'h08, 8'h00, 8'h00, 8'h00, 8'hFF, 5'h1F, 5'h00, 8'h00, 8'hFF, 8'h00,
      8'hFF, 8'hB0, 8'hFF, 8'h40, 8'h0F, 5'h00, 5'h1F, 5'h00, 5'h1F},
    '{16'h0003, 8'h0D, 8'h00, 8'h00, 8'h00, 8'h00, 5'h1F, 5'h00, 8'h00, 8'hFF, 8'h00,
      8'hFF, 8'h00, 8'hFF, 8'h00, 8'hFF, 5'h00, 5'h18, 5'h1D, 5'h07}
  };
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] pin_e_in, pin_f_in;
  logic [4:0] pin_g_in;
  pefg_row_t cur;
  int n_errors = 0;
  int comparisons = 0;
  wire global_pullup_disable, legacy_compat_mode, serial0_rx_enable, serial0_tx_enable;
  wire serial0_sync_select, timer3_compare_b_en, timer3_compare_c_en, ext_irq_line_7_en;
  wire ext_irq_line_6_en, ext_irq_line_5_en, ext_irq_line_4_en, test_port_enable;
  wire tap_shift_instr_state, tap_shift_data_state, timer0_async_select, ext_memory_enable;
  wire serial0_tx_out, serial0_ext_clock, timer3_compare_b_out, timer3_compare_c_out;
  wire test_data_out, ext_mem_latch_strobe, ext_mem_read_strobe, ext_mem_write_strobe;
  wire [7:0] lvl, port_e_data, port_e_direction, port_f_data, port_f_direction;
  wire [4:0] port_g_data, port_g_direction;
  wire [7:0] pin_e_pullup, pin_e_oe_n, pin_e_out, port_e_din;
  wire [7:0] pin_f_pullup, pin_f_oe_n, pin_f_out, port_f_din;
  wire [4:0] pin_g_pullup, pin_g_oe_n, pin_g_out, port_g_din;
  wire [83:0] obs = {pin_e_pullup, pin_e_oe_n, pin_e_out, port_e_din, pin_f_pullup,
    pin_f_oe_n, pin_f_out, port_f_din, pin_g_pullup, pin_g_oe_n, pin_g_out, port_g_din};
  assign {global_pullup_disable, legacy_compat_mode, serial0_rx_enable, serial0_tx_enable,
    serial0_sync_select, timer3_compare_b_en, timer3_compare_c_en, ext_irq_line_7_en,
    ext_irq_line_6_en, ext_irq_line_5_en, ext_irq_line_4_en, test_port_enable,
    tap_shift_instr_state, tap_shift_data_state, timer0_async_select, ext_memory_enable} = cur.ctl;
  assign {lvl, port_e_data, port_e_direction, port_f_data, port_f_direction, port_g_data,
    port_g_direction} = {cur.lvl, cur.ed, cur.edir, cur.fd, cur.fdir, cur.gd, cur.gdir};
  pefg_periph_model u_pefg_periph_model (.*);
  pefg_override_mux u_pefg_override_mux (.*);
  always #25 core_clk = ~core_clk;
  task check(input logic [83:0] got, input logic [83:0] want);
    comparisons++;
    if (got !== want) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask
  task results;
    $display("comparisons=%0d n_errors=%0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // the whole run is well under a hundred cycles
  initial begin
    repeat (2000) @(posedge core_clk);
    n_errors++;
    results;
  end
  initial begin
    cur = '0;
    pin_e_in = 8'hFF;
    pin_f_in = 8'hFF;
    pin_g_in = 5'h1F;
    repeat (10) @(posedge core_clk);
    #5 rst = 1'b0;
    foreach (rows[i]) begin
      cur = rows[i];
      repeat (3) @(posedge core_clk);
      #5 check(obs, rows[i][83:0]);
    end
    // a pad change needs two sync stages plus the output flop
    cur = '0;
    pin_e_in = 8'hFE;
    repeat (2) @(posedge core_clk);
    #5 check(port_e_din, 8'hFF);
    @(posedge core_clk);
    #5 check(port_e_din, 8'hFE);
    cur.ctl = 16'h1000;
    pin_e_in = 8'hFF;
    @(posedge core_clk);
    #5 check(pin_e_oe_n[1], 1'b0);
    // reset with the test port on must not drop its pull-ups
    cur.ctl = 16'h0010;
    repeat (2) @(posedge core_clk);
    #5 rst = 1'b1;
    #10 check({pin_f_pullup, pin_f_oe_n, pin_e_oe_n, pin_g_oe_n, port_e_din},
      {8'hB0, 8'hFF, 8'hFF, 5'h1F, 8'h00});
    @(posedge core_clk);
    #5 rst = 1'b0;
    repeat (3) @(posedge core_clk);
    #5 check({pin_f_pullup, pin_f_oe_n, port_f_din}, {8'hB0, 8'hFF, 8'h0F});
    cur.ctl = 16'h0014;
    @(posedge core_clk);
    #5 check(pin_f_oe_n, 8'hBF);
    results;
  end
endmodule
